// ---- src/pcma_pkg.sv ----
// Function
// - The held selector picks which control register a port-control move reaches.
// - Selector resets to 1Fh so moves write the direction registers.
// - Selector bit 4 clear: move copies the control register into W.
// - Selector bit 4 set: move copies W into the control register.
// - Comparator and wake pending on Port B swap with W regardless of bit 4.
// - Wake edge and wake enable on Port B take W regardless of bit 4.
// - Selector holds its value until software writes it again.
// - Port B reaches timer 1, Port C timer 2; 10h on Port B clears timer 1.
// - 0C/1C Schmitt B-E, 0D/1D level, 0E/1E pull-up, 0F/1F direction A-E.
// - Direction bit set means input, clear means output; all set at reset.
// - Pull-up bit set disconnects, clear connects the pull-up; all set at reset.
// - Bit 0 of each port register controls that port's lowest pin.
// - Port A has four pins, Ports B to E eight pins each.
package pcma_pkg;
  localparam int PCMA_PORT_CNT = 5;
  localparam int PCMA_PA_WIDTH = 4;
  localparam int PCMA_PORT_WIDTH = 8;
  localparam logic [2:0] PCMA_PORT_A = 3'h0;
  localparam logic [2:0] PCMA_PORT_B = 3'h1;
  localparam logic [2:0] PCMA_PORT_C = 3'h2;
  localparam logic [7:0] PCMA_MODE_RST = 8'h1f;
  localparam int PCMA_MODE_RW_BIT = 4;
  localparam logic [3:0] PCMA_SEL_CMP = 4'h8;
  localparam logic [3:0] PCMA_SEL_WKPND = 4'h9;
  localparam logic [3:0] PCMA_SEL_WKED = 4'ha;
  localparam logic [3:0] PCMA_SEL_WKEN = 4'hb;
  localparam logic [3:0] PCMA_SEL_ST = 4'hc;
  localparam logic [3:0] PCMA_SEL_LVL = 4'hd;
  localparam logic [3:0] PCMA_SEL_PLP = 4'he;
  localparam logic [3:0] PCMA_SEL_DIR = 4'hf;
  localparam logic [2:0] PCMA_TMR_CLR_IDX = 3'h0;
  localparam logic [2:0] PCMA_TMR_WR_MIN = 3'h2;
  localparam logic [7:0] PCMA_CFG_RST = 8'hff;
  localparam logic [7:0] PCMA_TMR_RST = 8'h00;
  localparam logic [7:0] PCMA_WKPND_RST = 8'h00;
  localparam int PCMA_CMP_RESULT_BIT = 0;
  typedef enum logic [2:0] {
    PCMA_ACT_NONE,
    PCMA_ACT_READ,
    PCMA_ACT_WRITE,
    PCMA_ACT_SWAP,
    PCMA_ACT_CLEAR
  } pcma_act_t;
endpackage : pcma_pkg

// ---- src/pcma_cfg_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcma_cfg_reg #(
  parameter int WIDTH = 8,
  parameter logic [7:0] RESET = 8'hff
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_q
);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_q <= RESET[WIDTH-1:0];
    end else if (i_we) begin
      o_q <= i_wdata;
    end
  end
endmodule : pcma_cfg_reg
`default_nettype wire

// ---- src/pcma_timer_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcma_timer_regs
  import pcma_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [2:0] i_idx,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_capture_low,
  input wire logic [7:0] i_capture_high,
  output logic [7:0] o_rdata,
  output logic [5:0][7:0] o_regs
);
  // Index 2..7: compare2 low/high, compare1 low/high, control B/A
  genvar g;
  generate
    for (g = 2; g < 8; g++) begin : g_reg
      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
          o_regs[g-2] <= PCMA_TMR_RST;
        end else if (i_we && i_idx == 3'(g)) begin
          o_regs[g-2] <= i_wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    case (i_idx)
      3'h0: o_rdata = i_capture_low;
      3'h1: o_rdata = i_capture_high;
      default: o_rdata = o_regs[i_idx - PCMA_TMR_WR_MIN];
    endcase
  end
endmodule : pcma_timer_regs
`default_nettype wire

// ---- src/pcma_port_cfg.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcma_port_cfg
  import pcma_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_mode_wdata,
  input wire logic i_ctl_mov,
  input wire logic [2:0] i_ctl_port,
  input wire logic [7:0] i_w_data,
  input wire logic [7:0] i_t1_capture_low,
  input wire logic [7:0] i_t1_capture_high,
  input wire logic [7:0] i_t2_capture_low,
  input wire logic [7:0] i_t2_capture_high,
  input wire logic i_cmp_result,
  input wire logic [7:0] i_wake_event,
  output logic [7:0] o_mode,
  output logic o_w_wr,
  output logic [7:0] o_w_data,
  output logic o_t1_clear,
  output logic [3:0] o_dir_a,
  output logic [7:0] o_dir_b,
  output logic [7:0] o_dir_c,
  output logic [7:0] o_dir_d,
  output logic [7:0] o_dir_e,
  output logic [3:0] o_pullup_cfg_port_a,
  output logic [7:0] o_pullup_cfg_port_b,
  output logic [7:0] o_pullup_cfg_port_c,
  output logic [7:0] o_pullup_cfg_port_d,
  output logic [7:0] o_pullup_cfg_port_e,
  output logic [3:0] o_input_level_cfg_port_a,
  output logic [7:0] o_input_level_cfg_port_b,
  output logic [7:0] o_input_level_cfg_port_c,
  output logic [7:0] o_input_level_cfg_port_d,
  output logic [7:0] o_input_level_cfg_port_e,
  output logic [7:0] o_schmitt_cfg_port_b,
  output logic [7:0] o_schmitt_cfg_port_c,
  output logic [7:0] o_schmitt_cfg_port_d,
  output logic [7:0] o_schmitt_cfg_port_e,
  output logic [7:0] o_comparator_ctrl,
  output logic [7:0] o_wake_pending_flags,
  output logic [7:0] o_wake_edge_select,
  output logic [7:0] o_wake_enable_mask,
  output logic [7:0] o_timer1_compare2_low,
  output logic [7:0] o_timer1_compare2_high,
  output logic [7:0] o_timer1_compare1_low,
  output logic [7:0] o_timer1_compare1_high,
  output logic [7:0] o_timer1_control_b,
  output logic [7:0] o_timer1_control_a,
  output logic [7:0] o_timer2_compare2_low,
  output logic [7:0] o_timer2_compare2_high,
  output logic [7:0] o_timer2_compare1_low,
  output logic [7:0] o_timer2_compare1_high,
  output logic [7:0] o_timer2_control_b,
  output logic [7:0] o_timer2_control_a
);
  import pcma_pkg::*;

  logic [7:0] mode_r;
  logic [3:0] sel;
  logic rw_bit;
  logic mode_ok;
  logic [2:0] tmr_idx;
  pcma_act_t act;
  logic [7:0] rd_data;
  logic [7:0] swap_old;
  logic [4:0][7:0] dir_q;
  logic [4:0][7:0] plp_q;
  logic [4:0][7:0] lvl_q;
  logic [4:0][7:0] st_q;
  logic [7:0] t1_rdata;
  logic [7:0] t2_rdata;
  logic [5:0][7:0] t1_regs;
  logic [5:0][7:0] t2_regs;
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic [7:1] cmp_ctrl_r;
  logic [7:0] wkpnd_r;
  logic [7:0] wkpnd_nxt;
  logic [7:0] wked_r;
  logic [7:0] wken_r;
  logic is_b;
  logic is_c;

  // Selector, not memory-mapped, held until rewritten
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      mode_r <= PCMA_MODE_RST;
    end else if (i_mode_wr) begin
      mode_r <= i_mode_wdata;
    end
  end

  assign sel = mode_r[3:0];
  assign rw_bit = mode_r[PCMA_MODE_RW_BIT];
  assign mode_ok = (mode_r[7:5] == 3'h0);
  assign tmr_idx = mode_r[2:0];
  assign is_b = (i_ctl_port == PCMA_PORT_B);
  assign is_c = (i_ctl_port == PCMA_PORT_C);

  // Action decode from selector and port
  always_comb begin
    act = PCMA_ACT_NONE;
    if (i_ctl_mov && mode_ok && i_ctl_port < 3'(PCMA_PORT_CNT)) begin
      case (sel)
        PCMA_SEL_CMP, PCMA_SEL_WKPND: begin
          if (is_b) begin
            act = PCMA_ACT_SWAP;
          end
        end
        PCMA_SEL_WKED, PCMA_SEL_WKEN: begin
          if (is_b) begin
            act = PCMA_ACT_WRITE;
          end
        end
        PCMA_SEL_ST: begin
          if (i_ctl_port != PCMA_PORT_A) begin
            act = rw_bit ? PCMA_ACT_WRITE : PCMA_ACT_READ;
          end
        end
        PCMA_SEL_LVL, PCMA_SEL_PLP, PCMA_SEL_DIR: begin
          act = rw_bit ? PCMA_ACT_WRITE : PCMA_ACT_READ;
        end
        default: begin
          if (is_b || is_c) begin
            if (!rw_bit) begin
              act = PCMA_ACT_READ;
            end else if (tmr_idx >= PCMA_TMR_WR_MIN) begin
              act = PCMA_ACT_WRITE;
            end else if (tmr_idx == PCMA_TMR_CLR_IDX && is_b) begin
              act = PCMA_ACT_CLEAR;
            end
          end
        end
      endcase
    end
  end

  // Per-port configuration banks
  genvar p;
  generate
    for (p = 0; p < PCMA_PORT_CNT; p++) begin : g_port
      localparam int W = (p == 0) ? PCMA_PA_WIDTH : PCMA_PORT_WIDTH;
      logic hit;
      logic [W-1:0] dq;
      logic [W-1:0] pq;
      logic [W-1:0] lq;
      assign hit = (act == PCMA_ACT_WRITE) && (i_ctl_port == 3'(p));
      pcma_cfg_reg #(.WIDTH(W), .RESET(PCMA_CFG_RST)) u_dir (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(hit && sel == PCMA_SEL_DIR),
        .i_wdata(i_w_data[W-1:0]),
        .o_q(dq)
      );
      pcma_cfg_reg #(.WIDTH(W), .RESET(PCMA_CFG_RST)) u_plp (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(hit && sel == PCMA_SEL_PLP),
        .i_wdata(i_w_data[W-1:0]),
        .o_q(pq)
      );
      pcma_cfg_reg #(.WIDTH(W), .RESET(PCMA_CFG_RST)) u_lvl (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_we(hit && sel == PCMA_SEL_LVL),
        .i_wdata(i_w_data[W-1:0]),
        .o_q(lq)
      );
      if (p == 0) begin : g_narrow
        assign dir_q[p] = {4'h0, dq};
        assign plp_q[p] = {4'h0, pq};
        assign lvl_q[p] = {4'h0, lq};
        assign st_q[p] = 8'h00;
      end else begin : g_wide
        assign dir_q[p] = dq;
        assign plp_q[p] = pq;
        assign lvl_q[p] = lq;
        pcma_cfg_reg #(.WIDTH(W), .RESET(PCMA_CFG_RST)) u_st (
          .i_sys_clk(i_sys_clk),
          .i_rstn(i_rstn),
          .i_we(hit && sel == PCMA_SEL_ST),
          .i_wdata(i_w_data[W-1:0]),
          .o_q(st_q[p])
        );
      end
    end
  endgenerate

  // Timer register sets
  pcma_timer_regs u_t1 (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_we(act == PCMA_ACT_WRITE && is_b && !sel[3]),
    .i_idx(tmr_idx),
    .i_wdata(i_w_data),
    .i_capture_low(i_t1_capture_low),
    .i_capture_high(i_t1_capture_high),
    .o_rdata(t1_rdata),
    .o_regs(t1_regs)
  );
  pcma_timer_regs u_t2 (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_we(act == PCMA_ACT_WRITE && is_c && !sel[3]),
    .i_idx(tmr_idx),
    .i_wdata(i_w_data),
    .i_capture_low(i_t2_capture_low),
    .i_capture_high(i_t2_capture_high),
    .o_rdata(t2_rdata),
    .o_regs(t2_regs)
  );

  // Comparator result synchroniser
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= i_cmp_result;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  assign swap_old = (sel == PCMA_SEL_CMP) ? {cmp_ctrl_r, cmp_sync_r} : wkpnd_r;

  // Comparator control bits
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cmp_ctrl_r <= PCMA_CFG_RST[7:1];
    end else if (act == PCMA_ACT_SWAP && sel == PCMA_SEL_CMP) begin
      cmp_ctrl_r <= i_w_data[7:1];
    end
  end

  // Wake pending: a new edge wins over the swap clear
  always_comb begin
    wkpnd_nxt = wkpnd_r;
    if (act == PCMA_ACT_SWAP && sel == PCMA_SEL_WKPND) begin
      wkpnd_nxt = i_w_data;
    end
    wkpnd_nxt = wkpnd_nxt | i_wake_event;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wkpnd_r <= PCMA_WKPND_RST;
    end else begin
      wkpnd_r <= wkpnd_nxt;
    end
  end

  // Wake edge and enable
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wked_r <= PCMA_CFG_RST;
      wken_r <= PCMA_CFG_RST;
    end else if (act == PCMA_ACT_WRITE && is_b) begin
      if (sel == PCMA_SEL_WKED) begin
        wked_r <= i_w_data;
      end
      if (sel == PCMA_SEL_WKEN) begin
        wken_r <= i_w_data;
      end
    end
  end

  // Read data mux
  always_comb begin
    case (sel)
      PCMA_SEL_ST: rd_data = st_q[i_ctl_port];
      PCMA_SEL_LVL: rd_data = lvl_q[i_ctl_port];
      PCMA_SEL_PLP: rd_data = plp_q[i_ctl_port];
      PCMA_SEL_DIR: rd_data = dir_q[i_ctl_port];
      default: rd_data = is_b ? t1_rdata : t2_rdata;
    endcase
  end

  // W return path and timer clear pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_w_wr <= 1'b0;
      o_w_data <= 8'h00;
      o_t1_clear <= 1'b0;
    end else begin
      o_w_wr <= (act == PCMA_ACT_READ) || (act == PCMA_ACT_SWAP);
      o_t1_clear <= (act == PCMA_ACT_CLEAR);
      if (act == PCMA_ACT_READ) begin
        o_w_data <= rd_data;
      end else if (act == PCMA_ACT_SWAP) begin
        o_w_data <= swap_old;
      end
    end
  end

  assign o_mode = mode_r;
  assign o_dir_a = dir_q[0][3:0];
  assign o_dir_b = dir_q[1];
  assign o_dir_c = dir_q[2];
  assign o_dir_d = dir_q[3];
  assign o_dir_e = dir_q[4];
  assign o_pullup_cfg_port_a = plp_q[0][3:0];
  assign o_pullup_cfg_port_b = plp_q[1];
  assign o_pullup_cfg_port_c = plp_q[2];
  assign o_pullup_cfg_port_d = plp_q[3];
  assign o_pullup_cfg_port_e = plp_q[4];
  assign o_input_level_cfg_port_a = lvl_q[0][3:0];
  assign o_input_level_cfg_port_b = lvl_q[1];
  assign o_input_level_cfg_port_c = lvl_q[2];
  assign o_input_level_cfg_port_d = lvl_q[3];
  assign o_input_level_cfg_port_e = lvl_q[4];
  assign o_schmitt_cfg_port_b = st_q[1];
  assign o_schmitt_cfg_port_c = st_q[2];
  assign o_schmitt_cfg_port_d = st_q[3];
  assign o_schmitt_cfg_port_e = st_q[4];
  assign o_comparator_ctrl = {cmp_ctrl_r, cmp_sync_r};
  assign o_wake_pending_flags = wkpnd_r;
  assign o_wake_edge_select = wked_r;
  assign o_wake_enable_mask = wken_r;
  assign o_timer1_compare2_low = t1_regs[0];
  assign o_timer1_compare2_high = t1_regs[1];
  assign o_timer1_compare1_low = t1_regs[2];
  assign o_timer1_compare1_high = t1_regs[3];
  assign o_timer1_control_b = t1_regs[4];
  assign o_timer1_control_a = t1_regs[5];
  assign o_timer2_compare2_low = t2_regs[0];
  assign o_timer2_compare2_high = t2_regs[1];
  assign o_timer2_compare1_low = t2_regs[2];
  assign o_timer2_compare1_high = t2_regs[3];
  assign o_timer2_control_b = t2_regs[4];
  assign o_timer2_control_a = t2_regs[5];
endmodule : pcma_port_cfg
`default_nettype wire

// ---- bench/pcma_port_cfg_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcma_port_cfg_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_mode_wr,
  input wire logic [7:0] i_mode_wdata,
  input wire logic i_ctl_mov,
  input wire logic [2:0] i_ctl_port,
  input wire logic [7:0] i_w_data,
  input wire logic [7:0] i_wake_event,
  input wire logic [7:0] o_mode,
  input wire logic o_w_wr,
  input wire logic [7:0] o_w_data,
  input wire logic o_t1_clear,
  input wire logic [3:0] o_dir_a,
  input wire logic [7:0] o_dir_b,
  input wire logic [7:0] o_wake_pending_flags,
  input wire logic [7:0] o_wake_edge_select
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_mov(logic [7:0] sel, logic [2:0] prt);
    i_ctl_mov && o_mode == sel && i_ctl_port == prt;
  endsequence
  sequence s_rd(logic [7:0] val);
    o_w_wr && o_w_data == val;
  endsequence
  sequence s_movb(logic [3:0] sel);
    i_ctl_mov && o_mode[7:5] == 3'h0 && o_mode[3:0] == sel && i_ctl_port == 3'h1;
  endsequence
  chk_reset_vals: assert property ($rose(i_rstn) |-> o_mode == 8'h1f && o_dir_b == 8'hff && o_dir_a == 4'hf)
    else $error("selector or direction reset value wrong");
  chk_mode_load: assert property (i_mode_wr |=> o_mode == $past(i_mode_wdata))
    else $error("selector not loaded");
  chk_mode_hold: assert property (!i_mode_wr |=> $stable(o_mode))
    else $error("selector changed without write");
  chk_dir_read: assert property (s_mov(8'h0f, 3'h1) |=> s_rd($past(o_dir_b)))
    else $error("direction read wrong");
  chk_pa_read: assert property (s_mov(8'h0f, 3'h0) |=> s_rd({4'h0, $past(o_dir_a)}))
    else $error("port A read wrong");
  chk_dir_write: assert property (s_mov(8'h1f, 3'h1) |=> o_dir_b == $past(i_w_data) && !o_w_wr)
    else $error("direction write wrong");
  chk_pend_swap: assert property (s_movb(4'h9) |=> s_rd($past(o_wake_pending_flags)))
    else $error("pending swap wrong");
  chk_edge_write: assert property (s_movb(4'ha) |=> o_wake_edge_select == $past(i_w_data) && !o_w_wr)
    else $error("edge select write wrong");
  chk_pend_write: assert property (s_movb(4'h9)
    |=> o_wake_pending_flags == ($past(i_w_data) | $past(i_wake_event)))
    else $error("pending write or new edge lost");
  chk_clear_cause: assert property (o_t1_clear |-> $past(i_ctl_mov && o_mode == 8'h10 && i_ctl_port == 3'h1))
    else $error("timer clear without cause");
  chk_clear_pulse: assert property (s_mov(8'h10, 3'h1) |=> o_t1_clear)
    else $error("timer clear missing");
  chk_unmapped_quiet: assert property (i_ctl_mov && (o_mode[7:5] != 3'h0 || o_mode[4:0] == 5'h11 || i_ctl_port > 3'h4)
    |=> !o_w_wr && !o_t1_clear)
    else $error("unmapped move acted");
  chk_idle_quiet: assert property (!i_ctl_mov |=> !o_w_wr && $stable(o_dir_b))
    else $error("activity without move");
endmodule : pcma_port_cfg_chk
bind pcma_port_cfg pcma_port_cfg_chk u_chk (.i_sys_clk, .i_rstn, .i_mode_wr, .i_mode_wdata, .i_ctl_mov,
  .i_ctl_port, .i_w_data, .i_wake_event, .o_mode, .o_w_wr, .o_w_data, .o_t1_clear, .o_dir_a, .o_dir_b,
  .o_wake_pending_flags,
  .o_wake_edge_select);
`default_nettype wire

// ---- bench/pcma_cpu_mdl.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcma_cpu_mdl (
  input wire logic i_sys_clk,
  input wire logic i_ld,
  input wire logic [7:0] i_ld_val,
  input wire logic i_w_wr,
  input wire logic [7:0] i_w_data,
  output logic [7:0] o_w
);
  // Working register, loaded by the block or by the program
  always_ff @(posedge i_sys_clk) begin
    if (i_w_wr) begin
      o_w <= i_w_data;
    end else if (i_ld) begin
      o_w <= i_ld_val;
    end
  end
endmodule : pcma_cpu_mdl
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import pcma_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_mode_wr = 1'b0;
  logic i_ctl_mov = 1'b0;
  logic i_cmp_result = 1'b0;
  logic ld = 1'b0;
  logic [2:0] i_ctl_port = 3'h0;
  logic [7:0] i_mode_wdata = 8'h00;
  logic [7:0] i_wake_event = 8'h00;
  logic [7:0] ldv = 8'h00;
  logic [7:0] v;
  logic [7:0] cap [4];
  logic [7:0] ec [4][5];
  logic [7:0] et [2][6];
  logic [7:0] ew [4];
  logic [7:0] wsel [4] = '{8'h0a, 8'h1a, 8'h0b, 8'h1b};
  logic [7:0] bad [6] = '{8'h11, 8'h11, 8'h3f, 8'h10, 8'h05, 8'h0f};
  wire [7:0] cf [4][5];
  wire [7:0] tm [2][6];
  wire [7:0] wk [4];
  wire [7:0] md;
  wire [7:0] wd;
  wire [7:0] w;
  wire tclr;
  wire wwr;
  int seed = 64;
  int errors = 0;
  int total_checks = 0;
  int nclr = 0;
  pcma_port_cfg DUT (.i_sys_clk, .i_rstn, .i_mode_wr, .i_mode_wdata, .i_ctl_mov, .i_ctl_port, .i_w_data(w),
    .i_t1_capture_low(cap[0]), .i_t1_capture_high(cap[1]), .i_t2_capture_low(cap[2]), .i_t2_capture_high(cap[3]),
    .i_cmp_result, .i_wake_event, .o_mode(md), .o_w_wr(wwr), .o_w_data(wd), .o_t1_clear(tclr),
    .o_dir_a(cf[3][0][3:0]), .o_dir_b(cf[3][1]), .o_dir_c(cf[3][2]), .o_dir_d(cf[3][3]), .o_dir_e(cf[3][4]),
    .o_pullup_cfg_port_a(cf[2][0][3:0]), .o_pullup_cfg_port_b(cf[2][1]), .o_pullup_cfg_port_c(cf[2][2]),
    .o_pullup_cfg_port_d(cf[2][3]), .o_pullup_cfg_port_e(cf[2][4]), .o_input_level_cfg_port_a(cf[1][0][3:0]),
    .o_input_level_cfg_port_b(cf[1][1]), .o_input_level_cfg_port_c(cf[1][2]), .o_input_level_cfg_port_d(cf[1][3]),
    .o_input_level_cfg_port_e(cf[1][4]), .o_schmitt_cfg_port_b(cf[0][1]), .o_schmitt_cfg_port_c(cf[0][2]),
    .o_schmitt_cfg_port_d(cf[0][3]), .o_schmitt_cfg_port_e(cf[0][4]), .o_comparator_ctrl(wk[0]),
    .o_wake_pending_flags(wk[1]), .o_wake_edge_select(wk[2]), .o_wake_enable_mask(wk[3]),
    .o_timer1_compare2_low(tm[0][0]), .o_timer1_compare2_high(tm[0][1]), .o_timer1_compare1_low(tm[0][2]),
    .o_timer1_compare1_high(tm[0][3]), .o_timer1_control_b(tm[0][4]), .o_timer1_control_a(tm[0][5]),
    .o_timer2_compare2_low(tm[1][0]), .o_timer2_compare2_high(tm[1][1]), .o_timer2_compare1_low(tm[1][2]),
    .o_timer2_compare1_high(tm[1][3]), .o_timer2_control_b(tm[1][4]), .o_timer2_control_a(tm[1][5]));
  pcma_cpu_mdl u_cpu (.i_sys_clk, .i_ld(ld), .i_ld_val(ldv), .i_w_wr(wwr), .i_w_data(wd), .o_w(w));
  // Port A has no upper bits and no Schmitt register
  for (genvar s = 0; s < 4; s++) begin : g_pad
    assign cf[s][0][7:4] = 4'h0;
  end
  assign cf[0][0][3:0] = 4'h0;
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (tclr === 1'b1) nclr++;
  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction : rnd
  function automatic logic [7:0] msk(int p);
    return (p == 0) ? 8'h0f : 8'hff;
  endfunction : msk
  function automatic logic [7:0] t_exp(int t, int k);
    if (k < 2) return cap[t * 2 + k];
    return et[t][k - 2];
  endfunction : t_exp
  task automatic init_model;
    foreach (ec[s, p]) ec[s][p] = msk(p);
    foreach (et[t, k]) et[t][k] = 8'h00;
    ew = '{8'hff, 8'h00, 8'hff, 8'hff};
  endtask : init_model
  task automatic mw(input logic [7:0] m);
    @(negedge i_sys_clk);
    i_mode_wr = 1'b1;
    i_mode_wdata = m;
    @(negedge i_sys_clk);
    i_mode_wr = 1'b0;
  endtask : mw
  task automatic mv(input logic [2:0] p, input logic [7:0] d);
    @(negedge i_sys_clk);
    ld = 1'b1;
    ldv = d;
    @(negedge i_sys_clk);
    ld = 1'b0;
    i_ctl_mov = 1'b1;
    i_ctl_port = p;
    @(negedge i_sys_clk);
    i_ctl_mov = 1'b0;
    @(negedge i_sys_clk);
  endtask : mv
  task automatic check_all;
    foreach (ec[s, p]) if (s > 0 || p > 0) `CK("cfg", ec[s][p], cf[s][p] & msk(p))
    foreach (et[t, k]) `CK("tmr", et[t][k], tm[t][k])
    `CK("cmp", ew[0][7:1], wk[0][7:1])
    for (int k = 1; k < 4; k++) `CK("wake", ew[k], wk[k])
  endtask : check_all
  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    stop_test();
  end
  initial begin
    foreach (cap[i]) cap[i] = rnd();
    init_model();
    repeat (8) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    i_cmp_result = 1'b1;
    `CK("mode", 8'h1f, md)
    check_all();
    // Selectors used below are all defined ones, apart from the refusal table
    for (int s = 3; s >= 0; s--) begin
      if (s < 3) mw(8'h1c + 8'(s));
      for (int p = 0; p < 5; p++) begin
        v = rnd();
        mv(3'(p), v);
        `CK("w_keep", v, w)
        if (s > 0 || p > 0) ec[s][p] = v & msk(p);
      end
      check_all();
      mw(8'h0c + 8'(s));
      for (int p = 0; p < 5; p++) begin
        mv(3'(p), 8'h33);
        `CK("cfg_rd", (s > 0 || p > 0) ? ec[s][p] : 8'h33, w)
      end
    end
    for (int k = 0; k < 6; k++) begin
      mw(8'h12 + 8'(k));
      for (int t = 0; t < 2; t++) begin
        v = rnd();
        mv(3'(t + 1), v);
        et[t][k] = v;
      end
      mv(3'h3, v);
    end
    check_all();
    for (int k = 0; k < 8; k++) begin
      mw(8'(k));
      for (int t = 0; t < 3; t++) begin
        mv(3'(t + 1), 8'h5a);
        `CK("tmr_rd", (t == 2) ? 8'h5a : t_exp(t, k), w)
      end
    end
    foreach (wsel[k]) begin
      mw(wsel[k]);
      v = rnd();
      mv(3'h1, v);
      ew[2 + k / 2] = v;
      `CK("w_keep", v, w)
      mv(3'h2, 8'h77);
      `CK("w_keep", 8'h77, w)
    end
    mw(8'h08);
    v = rnd();
    mv(3'h1, v);
    `CK("cmp_old", {ew[0][7:1], 1'b1}, w)
    ew[0] = v;
    i_cmp_result = 1'b0;
    mw(8'h18);
    mv(3'h1, 8'h00);
    `CK("cmp_old", {v[7:1], 1'b0}, w)
    ew[0] = 8'h00;
    v = rnd();
    @(negedge i_sys_clk);
    i_wake_event = v;
    @(negedge i_sys_clk);
    i_wake_event = 8'h00;
    mw(8'h09);
    mv(3'h1, 8'h00);
    `CK("pend_old", v, w)
    mw(8'h19);
    v = rnd();
    mv(3'h1, v);
    `CK("pend_old", 8'h00, w)
    ew[1] = v;
    // Swap and a new edge in one cycle: the edge must survive
    @(negedge i_sys_clk);
    ld = 1'b1;
    ldv = 8'h0f;
    @(negedge i_sys_clk);
    ld = 1'b0;
    i_ctl_mov = 1'b1;
    i_ctl_port = 3'h1;
    i_wake_event = 8'h81;
    @(negedge i_sys_clk);
    i_ctl_mov = 1'b0;
    i_wake_event = 8'h00;
    @(negedge i_sys_clk);
    `CK("pend_old", ew[1], w)
    ew[1] = 8'h8f;
    check_all();
    mw(8'h10);
    mv(3'h2, 8'h00);
    mv(3'h1, 8'h00);
    `CK("clr_cnt", 1, nclr)
    foreach (bad[k]) begin
      mw(bad[k]);
      mv(3'(k), 8'hc3);
      `CK("w_keep", 8'hc3, w)
    end
    `CK("clr_cnt", 1, nclr)
    check_all();
    @(negedge i_sys_clk);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    init_model();
    `CK("mode", 8'h1f, md)
    check_all();
    stop_test();
  end
endmodule : tb
`default_nettype wire
